/* core/rac_pkg.sv */
// Purpose: Shared constants and types of the calendar, alarm and countdown block
// Assumes: Register pointer is four bits wide and wraps from 0fh to 00h
// Notes: Reset values and field masks are per register
package rac_pkg;
  localparam logic [3:0] OFS_CTRL1 = 4'h0;
  localparam logic [3:0] OFS_CTRL2 = 4'h1;
  localparam logic [3:0] OFS_SEC = 4'h2;
  localparam logic [3:0] OFS_MIN = 4'h3;
  localparam logic [3:0] OFS_HOUR = 4'h4;
  localparam logic [3:0] OFS_DAY = 4'h5;
  localparam logic [3:0] OFS_WDAY = 4'h6;
  localparam logic [3:0] OFS_MON = 4'h7;
  localparam logic [3:0] OFS_YEAR = 4'h8;
  localparam int OFS_CFG_LO = 9;
  localparam int OFS_CFG_HI = 14;
  localparam logic [3:0] OFS_AMIN = 4'h9;
  localparam logic [3:0] OFS_AHOUR = 4'ha;
  localparam logic [3:0] OFS_ADAY = 4'hb;
  localparam logic [3:0] OFS_AWDAY = 4'hc;
  localparam logic [3:0] OFS_CLKO = 4'hd;
  localparam logic [3:0] OFS_TCTL = 4'he;
  localparam logic [3:0] OFS_TVAL = 4'hf;
  localparam logic [6:0] DEV_ADDR = 7'h51;
  localparam int DIS_BIT = 7;
  localparam int CENT_BIT = 7;
  localparam int GATE_BIT = 7;
  localparam int TE_BIT = 7;
  localparam int TITP_BIT = 4;
  localparam int AF_BIT = 3;
  localparam int TF_BIT = 2;
  localparam int AIE_BIT = 1;
  localparam int TIE_BIT = 0;
  localparam logic [7:0] RST_SEC = 8'h80;
  localparam logic [7:0] RST_DAY = 8'h01;
  localparam logic [7:0] RST_MON = 8'h01;
  localparam logic [7:0] MSK_MIN = 8'h7f;
  localparam logic [7:0] MSK_HOUR = 8'h3f;
  localparam logic [7:0] MSK_DAY = 8'h3f;
  localparam logic [7:0] MSK_WDAY = 8'h07;
  localparam logic [7:0] MSK_MON = 8'h9f;
  localparam logic [7:0] CFG_MSK [9:14] = '{8'hff, 8'hbf, 8'hbf, 8'h87, 8'h83, 8'h83};
  localparam logic [7:0] CFG_RST [9:14] = '{8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h03};
  localparam int PRE_W = 15;
  localparam int PRE_4K = 2;
  localparam int PRE_1K = 4;
  localparam int PRE_64 = 8;
  localparam int PRE_32 = 9;
  localparam int PRE_1HZ = 14;
  localparam logic [5:0] SECS_PER_MIN_LAST = 6'd59;
  typedef enum logic [2:0] {
    BUS_IDLE = 3'h0, BUS_ADDR = 3'h1, BUS_ACK_A = 3'h3, BUS_RX = 3'h2,
    BUS_ACK_W = 3'h6, BUS_RD = 3'h7, BUS_ACK_R = 3'h5
  } rac_bus_state_type;
endpackage

/* core/rac_sync.sv */
// Purpose: Two-flop level synchroniser
// Assumes: Each bit is an independent level
// Notes: First stage feeds only the second
`timescale 1ns/10ps
module rac_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q_reg
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= '0;
      q_reg <= '0;
    end else begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end
endmodule

/* core/rac_prescaler.sv */
// Purpose: Oscillator prescaler, clock output and tick crossing
// Assumes: osc_clk is the free-running 32.768 kHz oscillator
// Notes: Ticks reach clk as one-cycle pulses
`timescale 1ns/10ps
module rac_prescaler (
  input wire logic osc_clk,
  input wire logic clk,
  input wire logic arst_n,
  input wire logic out_gate,
  input wire logic [1:0] out_sel,
  output logic tick_4k,
  output logic tick_64,
  output logic tick_1,
  output logic clock_output_pin
);
  import rac_pkg::*;
  logic [PRE_W-1:0] pre_reg;
  logic [2:0] cfg_s;
  logic [2:0] lvl_s;
  logic [2:0] lvl_d_reg;
  logic div_reg;
  logic div_sel;
  rac_sync #(.W(3)) u_cfg_sync (.clk(osc_clk), .arst_n(arst_n), .d({out_gate, out_sel}), .q_reg(cfg_s));
  assign div_sel = (cfg_s[1:0] == 2'b01) ? pre_reg[PRE_1K] :
                   (cfg_s[1:0] == 2'b10) ? pre_reg[PRE_32] : pre_reg[PRE_1HZ];
  always_ff @(posedge osc_clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_reg <= '0;
      div_reg <= 1'b0;
    end else begin
      pre_reg <= pre_reg + 15'h0001;
      div_reg <= cfg_s[2] & div_sel;
    end
  end
  // Gated oscillator or divided bit; low while gated off
  assign clock_output_pin = cfg_s[2] & ((cfg_s[1:0] == 2'b00) ? osc_clk : div_reg);
  rac_sync #(.W(3)) u_tick_sync (.clk(clk), .arst_n(arst_n),
    .d({pre_reg[PRE_4K], pre_reg[PRE_64], pre_reg[PRE_1HZ]}), .q_reg(lvl_s));
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lvl_d_reg <= '0;
    end else begin
      lvl_d_reg <= lvl_s;
    end
  end
  assign tick_4k = lvl_s[2] & !lvl_d_reg[2];
  assign tick_64 = lvl_s[1] & !lvl_d_reg[1];
  assign tick_1 = lvl_s[0] & !lvl_d_reg[0];
  a_clko_gated: assert property (@(posedge osc_clk) disable iff (!arst_n) !cfg_s[2] |-> !clock_output_pin)
    else $error("clock output not held low while gated");
endmodule

/* core/rac_rtc.sv */
// Purpose: Calendar counters, alarm, clock output control and countdown timer behind a two-wire slave
// Assumes: scl_in and sda_in are raw pins; osc_clk is the oscillator
// Notes: Open-drain pins drive low only
// Functional notes
// - Year is two BCD digits, tens high
// - Year wrap 99 to 00 flips century
// - Century bit sits in month register bit 7
// - Bus transfer blocks time counters 02h-08h
// - One blocked second applied after the transfer
// - Minute alarm: disable bit, BCD tens, units
// - Hour alarm: disable bit, bit 6 unused
// - Day alarm: disable bit, tens 0-3
// - Weekday alarm: disable bit, weekday bits 2-0
// - Alarm flag set when enabled fields first match
// - Alarm flag held until host clears it
// - Interrupt follows alarm flag when enabled
// - Gate bit low holds clock output low
// - Two bits select clock output frequency
// - Timer counts down, flags each period end
// - Timer flag cleared only by host write
// - Timer interrupt: pulse or flag level
// - Timer read returns live count
// - Timer enable bit, reset disabled
// - Two bits select countdown source clock
`timescale 1ns/10ps
module rac_rtc (
  input wire logic clk,
  input wire logic osc_clk,
  input wire logic arst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic int_out,
  output logic int_oe,
  output logic clock_output_pin
);
  import rac_pkg::*;
  logic [1:0] pin_s;
  logic scl_d_reg, sda_d_reg;
  logic scl_rise, scl_fall, start_cond, stop_cond;
  rac_bus_state_type st_reg;
  logic [3:0] cnt_reg, ptr_reg, wr_addr_reg;
  logic [7:0] sh_reg, wr_data_reg, rd_data;
  logic rw_reg, ptr_ph_reg, nack_reg, oe_reg, busy_reg, wr_stb_reg;
  logic [15:0] we;
  logic [7:0] rd_map [16];
  logic [7:0] sec_reg, min_reg, hour_reg, day_reg, wday_reg, mon_reg, year_reg;
  logic [7:0] sec_next, min_next, hour_next, day_next, wday_next, mon_next, year_next;
  logic [7:0] cfg_reg [9:14];
  logic [7:0] tcnt_reg, trld_reg, tcnt_next;
  logic [5:0] min_div_reg;
  logic tick_4k, tick_64, tick_1, tick_min, src_tick, timer_end;
  logic pend_reg, pend_next, inc;
  logic c_s, c_m, c_h, c_d, c_mo, c_y, leap;
  logic [7:0] day_max;
  logic af_reg, tf_reg, aie_reg, tie_reg, titp_reg, tpulse_reg, match_d_reg;
  logic m_min, m_hour, m_day, m_wday, any_en, match, int_act, int_oe_reg;

  function automatic logic [7:0] bcd_step(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
    if (v == hi) return lo;
    if (v[3:0] == 4'h9) return {v[7:4] + 4'h1, 4'h0};
    return v + 8'h01;
  endfunction

  // Serial slave front end
  rac_sync #(.W(2)) u_pin_sync (.clk(clk), .arst_n(arst_n), .d({scl_in, sda_in}), .q_reg(pin_s));
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= pin_s[1];
      sda_d_reg <= pin_s[0];
    end
  end
  assign scl_rise = pin_s[1] & !scl_d_reg;
  assign scl_fall = !pin_s[1] & scl_d_reg;
  assign start_cond = pin_s[1] & scl_d_reg & sda_d_reg & !pin_s[0];
  assign stop_cond = pin_s[1] & scl_d_reg & !sda_d_reg & pin_s[0];
  assign sda_out = 1'b0;
  assign sda_oe = oe_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= BUS_IDLE;
      cnt_reg <= '0;
      sh_reg <= '0;
      ptr_reg <= '0;
      rw_reg <= 1'b0;
      ptr_ph_reg <= 1'b0;
      nack_reg <= 1'b0;
      oe_reg <= 1'b0;
      busy_reg <= 1'b0;
      wr_stb_reg <= 1'b0;
      wr_addr_reg <= '0;
      wr_data_reg <= '0;
    end else begin
      wr_stb_reg <= 1'b0;
      if (stop_cond) begin
        st_reg <= BUS_IDLE;
        oe_reg <= 1'b0;
        busy_reg <= 1'b0;
      end else if (start_cond) begin
        st_reg <= BUS_ADDR;
        cnt_reg <= '0;
        oe_reg <= 1'b0;
      end else begin
        unique case (st_reg)
          BUS_IDLE: begin
          end
          BUS_ADDR: begin
            if (scl_rise) begin
              sh_reg <= {sh_reg[6:0], pin_s[0]};
              cnt_reg <= cnt_reg + 4'h1;
            end else if (scl_fall && cnt_reg == 4'h8) begin
              if (sh_reg[7:1] == DEV_ADDR) begin
                oe_reg <= 1'b1;
                rw_reg <= sh_reg[0];
                busy_reg <= 1'b1;
                st_reg <= BUS_ACK_A;
              end else begin
                st_reg <= BUS_IDLE;
              end
            end
          end
          BUS_ACK_A: begin
            if (scl_fall) begin
              cnt_reg <= '0;
              ptr_ph_reg <= !rw_reg;
              if (rw_reg) begin
                sh_reg <= rd_data;
                oe_reg <= !rd_data[7];
                st_reg <= BUS_RD;
              end else begin
                oe_reg <= 1'b0;
                st_reg <= BUS_RX;
              end
            end
          end
          BUS_RX: begin
            if (scl_rise) begin
              sh_reg <= {sh_reg[6:0], pin_s[0]};
              cnt_reg <= cnt_reg + 4'h1;
            end else if (scl_fall && cnt_reg == 4'h8) begin
              oe_reg <= 1'b1;
              st_reg <= BUS_ACK_W;
              ptr_ph_reg <= 1'b0;
              if (ptr_ph_reg) begin
                ptr_reg <= sh_reg[3:0];
              end else begin
                wr_stb_reg <= 1'b1;
                wr_addr_reg <= ptr_reg;
                wr_data_reg <= sh_reg;
                ptr_reg <= ptr_reg + 4'h1;
              end
            end
          end
          BUS_ACK_W: begin
            if (scl_fall) begin
              oe_reg <= 1'b0;
              cnt_reg <= '0;
              st_reg <= BUS_RX;
            end
          end
          BUS_RD: begin
            if (scl_fall) begin
              if (cnt_reg == 4'h7) begin
                oe_reg <= 1'b0;
                ptr_reg <= ptr_reg + 4'h1;
                st_reg <= BUS_ACK_R;
              end else begin
                cnt_reg <= cnt_reg + 4'h1;
                sh_reg <= {sh_reg[6:0], 1'b0};
                oe_reg <= !sh_reg[6];
              end
            end
          end
          BUS_ACK_R: begin
            if (scl_rise) begin
              nack_reg <= pin_s[0];
            end else if (scl_fall) begin
              cnt_reg <= '0;
              if (nack_reg) begin
                st_reg <= BUS_IDLE;
              end else begin
                sh_reg <= rd_data;
                oe_reg <= !rd_data[7];
                st_reg <= BUS_RD;
              end
            end
          end
          default: st_reg <= BUS_IDLE;
        endcase
      end
    end
  end

  // Register decode
  assign we = {15'h0000, wr_stb_reg} << wr_addr_reg;
  assign rd_map[0] = 8'h00;
  assign rd_map[1] = {3'h0, titp_reg, af_reg, tf_reg, aie_reg, tie_reg};
  assign rd_map[2] = sec_reg;
  assign rd_map[3] = min_reg;
  assign rd_map[4] = hour_reg;
  assign rd_map[5] = day_reg;
  assign rd_map[6] = wday_reg;
  assign rd_map[7] = mon_reg;
  assign rd_map[8] = year_reg;
  assign rd_map[15] = tcnt_reg;
  assign rd_data = rd_map[ptr_reg];

  genvar gi;
  for (gi = OFS_CFG_LO; gi <= OFS_CFG_HI; gi++) begin : g_cfg
    assign rd_map[gi] = cfg_reg[gi];
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        cfg_reg[gi] <= CFG_RST[gi];
      end else if (we[gi]) begin
        cfg_reg[gi] <= wr_data_reg & CFG_MSK[gi];
      end
    end
  end

  // Oscillator side
  rac_prescaler u_pre (
    .osc_clk(osc_clk),
    .clk(clk),
    .arst_n(arst_n),
    .out_gate(cfg_reg[OFS_CLKO][GATE_BIT]),
    .out_sel(cfg_reg[OFS_CLKO][1:0]),
    .tick_4k(tick_4k),
    .tick_64(tick_64),
    .tick_1(tick_1),
    .clock_output_pin(clock_output_pin)
  );

  // Second increment with one pending slot while blocked
  assign inc = !busy_reg & (tick_1 | pend_reg);
  assign pend_next = busy_reg ? (pend_reg | tick_1) : (pend_reg & tick_1);

  // Calendar carries
  assign leap = (year_reg[1:0] == {year_reg[4], 1'b0});
  assign day_max = (mon_reg[4:0] == 5'h02) ? (leap ? 8'h29 : 8'h28) :
                   (mon_reg[4:0] == 5'h04 || mon_reg[4:0] == 5'h06 ||
                    mon_reg[4:0] == 5'h09 || mon_reg[4:0] == 5'h11) ? 8'h30 : 8'h31;
  assign c_s = inc & (sec_reg[6:0] == 7'h59);
  assign c_m = c_s & (min_reg == 8'h59);
  assign c_h = c_m & (hour_reg == 8'h23);
  assign c_d = c_h & (day_reg == day_max);
  assign c_mo = c_d & (mon_reg[4:0] == 5'h12);
  assign c_y = c_mo & (year_reg == 8'h99);
  assign sec_next = we[OFS_SEC] ? wr_data_reg :
                    inc ? (bcd_step(sec_reg & 8'h7f, 8'h00, 8'h59) | (sec_reg & 8'h80)) : sec_reg;
  assign min_next = we[OFS_MIN] ? (wr_data_reg & MSK_MIN) : c_s ? bcd_step(min_reg, 8'h00, 8'h59) : min_reg;
  assign hour_next = we[OFS_HOUR] ? (wr_data_reg & MSK_HOUR) : c_m ? bcd_step(hour_reg, 8'h00, 8'h23) : hour_reg;
  assign day_next = we[OFS_DAY] ? (wr_data_reg & MSK_DAY) : c_h ? bcd_step(day_reg, 8'h01, day_max) : day_reg;
  assign wday_next = we[OFS_WDAY] ? (wr_data_reg & MSK_WDAY) : c_h ? bcd_step(wday_reg, 8'h00, 8'h06) : wday_reg;
  assign mon_next = we[OFS_MON] ? (wr_data_reg & MSK_MON) :
                    c_d ? (bcd_step(mon_reg & 8'h1f, 8'h01, 8'h12) | {mon_reg[CENT_BIT] ^ c_y, 7'h00}) :
                    mon_reg;
  assign year_next = we[OFS_YEAR] ? wr_data_reg : c_mo ? bcd_step(year_reg, 8'h00, 8'h99) : year_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sec_reg <= RST_SEC;
      min_reg <= '0;
      hour_reg <= '0;
      day_reg <= RST_DAY;
      wday_reg <= '0;
      mon_reg <= RST_MON;
      year_reg <= '0;
      pend_reg <= 1'b0;
    end else begin
      sec_reg <= sec_next;
      min_reg <= min_next;
      hour_reg <= hour_next;
      day_reg <= day_next;
      wday_reg <= wday_next;
      mon_reg <= mon_next;
      year_reg <= year_next;
      pend_reg <= pend_next;
    end
  end

  // Alarm compare over enabled fields
  assign m_min = cfg_reg[OFS_AMIN][DIS_BIT] | (cfg_reg[OFS_AMIN][6:0] == min_reg[6:0]);
  assign m_hour = cfg_reg[OFS_AHOUR][DIS_BIT] | (cfg_reg[OFS_AHOUR][5:0] == hour_reg[5:0]);
  assign m_day = cfg_reg[OFS_ADAY][DIS_BIT] | (cfg_reg[OFS_ADAY][5:0] == day_reg[5:0]);
  assign m_wday = cfg_reg[OFS_AWDAY][DIS_BIT] | (cfg_reg[OFS_AWDAY][2:0] == wday_reg[2:0]);
  assign any_en = !(cfg_reg[OFS_AMIN][DIS_BIT] & cfg_reg[OFS_AHOUR][DIS_BIT] &
                    cfg_reg[OFS_ADAY][DIS_BIT] & cfg_reg[OFS_AWDAY][DIS_BIT]);
  assign match = any_en & m_min & m_hour & m_day & m_wday;

  // Countdown source and period end
  assign tick_min = tick_1 & (min_div_reg == SECS_PER_MIN_LAST);
  assign src_tick = (cfg_reg[OFS_TCTL][1:0] == 2'b00) ? tick_4k :
                    (cfg_reg[OFS_TCTL][1:0] == 2'b01) ? tick_64 :
                    (cfg_reg[OFS_TCTL][1:0] == 2'b10) ? tick_1 : tick_min;
  assign timer_end = cfg_reg[OFS_TCTL][TE_BIT] & src_tick & (tcnt_reg == 8'h01);
  assign tcnt_next = we[OFS_TVAL] ? wr_data_reg :
                     timer_end ? trld_reg :
                     (cfg_reg[OFS_TCTL][TE_BIT] & src_tick & (tcnt_reg != 8'h00)) ? tcnt_reg - 8'h01 :
                     tcnt_reg;
  assign int_act = (aie_reg & af_reg) | (tie_reg & (titp_reg ? tpulse_reg : tf_reg));
  assign int_out = 1'b0;
  assign int_oe = int_oe_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tcnt_reg <= '0;
      trld_reg <= '0;
      min_div_reg <= '0;
      tpulse_reg <= 1'b0;
      match_d_reg <= 1'b0;
      int_oe_reg <= 1'b0;
    end else begin
      tcnt_reg <= tcnt_next;
      trld_reg <= we[OFS_TVAL] ? wr_data_reg : trld_reg;
      min_div_reg <= !tick_1 ? min_div_reg : tick_min ? 6'd0 : min_div_reg + 6'd1;
      tpulse_reg <= timer_end | (tpulse_reg & !tick_4k);
      match_d_reg <= match;
      int_oe_reg <= int_act;
    end
  end

  // Flags: a hardware set wins over a host clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      af_reg <= 1'b0;
      tf_reg <= 1'b0;
      aie_reg <= 1'b0;
      tie_reg <= 1'b0;
      titp_reg <= 1'b0;
    end else begin
      af_reg <= (match & !match_d_reg) | (af_reg & !(we[OFS_CTRL2] & !wr_data_reg[AF_BIT]));
      tf_reg <= timer_end | (tf_reg & !(we[OFS_CTRL2] & !wr_data_reg[TF_BIT]));
      aie_reg <= we[OFS_CTRL2] ? wr_data_reg[AIE_BIT] : aie_reg;
      tie_reg <= we[OFS_CTRL2] ? wr_data_reg[TIE_BIT] : tie_reg;
      titp_reg <= we[OFS_CTRL2] ? wr_data_reg[TITP_BIT] : titp_reg;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_release;
    $fell(busy_reg) ##0 pend_reg;
  endsequence
  a_year_wrap: assert property (c_y |=> (year_reg == 8'h00) && (mon_reg[7] != $past(mon_reg[7])))
    else $error("century not toggled on year wrap");
  a_busy_block: assert property (busy_reg && !wr_stb_reg |=> $stable(sec_reg))
    else $error("seconds advanced during transfer");
  a_pend_apply: assert property (s_release |=> sec_reg != $past(sec_reg))
    else $error("pending second not applied");
  a_alarm_set: assert property (match && !match_d_reg |=> af_reg)
    else $error("alarm flag not set on match");
  a_alarm_hold: assert property (af_reg && !we[OFS_CTRL2] |=> af_reg)
    else $error("alarm flag dropped without host clear");
  a_int_alarm: assert property (aie_reg && af_reg |=> int_oe)
    else $error("interrupt not following alarm flag");
  a_timer_end: assert property (timer_end && !we[OFS_TVAL] |=> tf_reg && tcnt_reg == $past(trld_reg))
    else $error("timer end did not flag and reload");
  a_timer_flag: assert property (tf_reg && !we[OFS_CTRL2] |=> tf_reg)
    else $error("timer flag cleared by hardware");
  a_pulse_mode: assert property (tie_reg && titp_reg && timer_end |=> ##1 int_oe)
    else $error("timer pulse missing on interrupt");
  a_timer_off: assert property (!cfg_reg[OFS_TCTL][TE_BIT] && !we[OFS_TVAL] |=> $stable(tcnt_reg))
    else $error("disabled timer still counting");
endmodule

/* tb/rac_host_model.sv */
// Purpose: Two-wire bus master standing in for the host controller
// Assumes: SDA has a pull-up; the bench forms the wired level
// Notes: Changes lines at the falling clk edge only
`timescale 1ns/10ps
module rac_host_model (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low,
  output logic rd_valid,
  output logic [7:0] rd_data
);
  int half = 5;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    rd_valid = 1'b0;
    rd_data = 8'h00;
  end
  task automatic pause();
    repeat (half) @(negedge clk);
  endtask
  // Start or repeated start
  task automatic start();
    @(negedge clk);
    sda_low = 1'b0;
    pause();
    scl = 1'b1;
    pause();
    sda_low = 1'b1;
    pause();
    scl = 1'b0;
  endtask
  task automatic stop();
    @(negedge clk);
    sda_low = 1'b1;
    pause();
    scl = 1'b1;
    pause();
    sda_low = 1'b0;
    pause();
  endtask
  task automatic bit_io(input logic b, output logic s);
    @(negedge clk);
    sda_low = !b;
    pause();
    scl = 1'b1;
    pause();
    s = sda;
    scl = 1'b0;
  endtask
  // Eight data bits then the acknowledge bit
  task automatic byte_io(input logic [7:0] wd, input logic rd, input logic last, output logic ack);
    logic [7:0] q;
    for (int i = 7; i >= 0; i--) begin
      bit_io(rd ? 1'b1 : wd[i], q[i]);
    end
    if (rd) begin
      rd_data = q;
      rd_valid = 1'b1;
      @(negedge clk);
      rd_valid = 1'b0;
    end
    bit_io(rd ? last : 1'b1, ack);
  endtask
endmodule

/* tb/tb.sv */
// Purpose: Self-checking bench of the calendar, alarm, clock output and timer block
// Assumes: Register access only over the two-wire bus
// Notes: Read results checked by a watcher against queued notes
`timescale 1ns/10ps
module tb;
  import rac_pkg::*;
  logic clk, osc_clk, arst_n, scl, sda_low, rd_valid, sda_out, sda_oe, int_out, int_oe, clock_output_pin;
  logic [7:0] rd_data;
  logic [7:0] notes [$];
  logic [15:0] seed;
  int miscompares, total_checks, cycles, rises;
  int clko_exp [4] = '{1024, 32, 1, 0};
  logic [7:0] clko_cfg [4] = '{8'h80, 8'h81, 8'h82, 8'h00};
  wire sda = !(sda_low || sda_oe);
  rac_host_model u_host (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low), .rd_valid(rd_valid),
    .rd_data(rd_data));
  rac_rtc u_dut (.clk(clk), .osc_clk(osc_clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .int_out(int_out), .int_oe(int_oe),
    .clock_output_pin(clock_output_pin));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    osc_clk = 1'b0;
    #1.3;
    forever #3 osc_clk = ~osc_clk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic head(input logic [7:0] b);
    logic ack;
    u_host.start();
    u_host.byte_io(b, 1'b0, 1'b0, ack);
    chk("address ack", 8'h00, {7'h0, ack});
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d [$]);
    logic ack;
    head({DEV_ADDR, 1'b0});
    u_host.byte_io({4'h0, a}, 1'b0, 1'b0, ack);
    foreach (d[k]) u_host.byte_io(d[k], 1'b0, 1'b0, ack);
    u_host.stop();
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e [$]);
    logic ack;
    notes = {notes, e};
    head({DEV_ADDR, 1'b0});
    u_host.byte_io({4'h0, a}, 1'b0, 1'b0, ack);
    head({DEV_ADDR, 1'b1});
    foreach (e[k]) u_host.byte_io(8'hff, 1'b1, k == e.size() - 1, ack);
    u_host.stop();
  endtask
  task automatic wait_int(input logic lvl);
    for (int k = 0; k < 2000 && int_oe !== lvl; k++) @(negedge clk);
    chk("interrupt", {7'h0, lvl}, {7'h0, int_oe});
  endtask
  always @(posedge clk) begin
    if (rd_valid === 1'b1 && notes.size() > 0) chk("read data", notes.pop_front(), rd_data);
  end
  always @(posedge clock_output_pin) rises++;
  always @(posedge clk) begin
    cycles++;
    if (cycles > 90000) begin
      miscompares++;
      wrap_up();
    end
  end
  initial begin
    arst_n = 1'b0;
    seed = 16'd23684;
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    repeat (5) @(negedge clk);
    rd(OFS_SEC, '{8'h80, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00});
    chk("open drain levels", 8'h00, {6'h0, sda_out, int_out});
    rd(OFS_AMIN, '{8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h03, 8'h00});
    wr(OFS_CTRL1, '{8'hff});
    rd(OFS_CTRL1, '{8'h00});
    wr(OFS_AHOUR, '{8'hff, 8'hff, 8'hff, 8'h83});
    rd(OFS_AHOUR, '{8'hbf, 8'hbf, 8'h87, 8'h83});
    wr(OFS_AHOUR, '{8'h80, 8'h80, 8'h80, 8'h80});
    seed = lfsr(seed);
    wr(OFS_TVAL, '{seed[7:0]});
    rd(OFS_TVAL, '{seed[7:0]});
    // Countdown at 4096 Hz from 5
    wr(OFS_TVAL, '{8'h05});
    wr(OFS_TCTL, '{8'h80});
    wr(OFS_CTRL2, '{8'h01});
    wait_int(1'b1);
    rd(OFS_CTRL2, '{8'h05});
    wr(OFS_CTRL2, '{8'h11});
    wait_int(1'b1);
    repeat (20) @(negedge clk);
    chk("pulse", 8'h00, {7'h0, int_oe});
    wr(OFS_TCTL, '{8'h03});
    repeat (200) @(negedge clk);
    rd(OFS_CTRL2, '{8'h15});
    wr(OFS_CTRL2, '{8'h00});
    rd(OFS_CTRL2, '{8'h00});
    // Minute alarm on the current minute
    wr(OFS_CTRL2, '{8'h02});
    wr(OFS_AMIN, '{8'h00});
    wait_int(1'b1);
    rd(OFS_CTRL2, '{8'h0a});
    wr(OFS_CTRL2, '{8'h02});
    rd(OFS_CTRL2, '{8'h02});
    chk("interrupt", 8'h00, {7'h0, int_oe});
    wr(OFS_AMIN, '{8'h80});
    // Edges in 6144 ns of a 6 ns oscillator
    for (int i = 0; i < 4; i++) begin
      wr(OFS_CLKO, '{clko_cfg[i]});
      rises = 0;
      repeat (1536) @(negedge clk);
      chk("clock edges", 8'h01, {7'h0, rises >= clko_exp[i] - 1 && rises <= clko_exp[i] + 1});
    end
    wr(OFS_CLKO, '{8'h80});
    wr(OFS_SEC, '{8'h59, 8'h59, 8'h23, 8'h31, 8'h06, 8'h12, 8'h99});
    repeat (50000) @(negedge clk);
    rd(OFS_SEC, '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h81, 8'h00});
    wrap_up();
  end
endmodule
